// file: core/pom_pkg.sv
package pom_pkg;

    // =========================================================
    // register port map
    // =========================================================
    localparam logic [7:0] ADDR_VIEW_CFG = 8'h00;
    localparam logic [7:0] ADDR_PFD_CFG = 8'h04;
    localparam logic [7:0] ADDR_AUX_CFG = 8'h08;
    localparam logic [7:0] ADDR_FRAC = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // =========================================================
    // field positions
    // =========================================================
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam int GPDATA_LSB = 4;
    localparam int GPDATA_W = 3;
    localparam int POL_BIT = 0;
    localparam int UP_PASS_BIT = 1;
    localparam int DN_PASS_BIT = 2;
    localparam int AUX_DLY_LSB = 2;
    localparam int AUX_DLY_W = 2;
    localparam int AUX_DIV_LSB = 4;
    localparam int AUX_DIV_W = 3;
    localparam int FRAC_W = 24;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [3:0] SEL_RST = 4'h0;
    localparam logic [2:0] PFD_RST = 3'h6;
    localparam logic [6:0] AUX_RST = 7'h00;

    // =========================================================
    // view select codes
    // =========================================================
    localparam logic [3:0] SEL_GPDATA = 4'h0;
    localparam logic [3:0] SEL_REFPATH = 4'h1;
    localparam logic [3:0] SEL_LOCKWIN = 4'h2;
    localparam logic [3:0] SEL_SLIP = 4'h3;
    localparam logic [3:0] SEL_FRACSTB = 4'h4;
    localparam logic [3:0] SEL_ACCUM = 4'h6;
    localparam logic [3:0] SEL_AUXOSC = 4'h7;
    localparam logic [3:0] SEL_MODOUT = 4'ha;

    // =========================================================
    // frac strobe sequencer states
    // =========================================================
    typedef enum logic [1:0] {
        POM_FS_IDLE = 2'b00,
        POM_FS_SYNC = 2'b01,
        POM_FS_PULSE = 2'b11
    } pom_fs_state_t;

endpackage : pom_pkg

// file: core/pom_aux_clk.sv
`timescale 1ns/10ps
// auxiliary clock shaper: delay tap then optional even divide
module pom_aux_clk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic aux_in,
    input wire logic [1:0] dly_mode,
    input wire logic [2:0] div_sel,
    output logic aux_out
);
    logic [3:0] dly_ff;
    logic dly_tap;
    logic [3:0] cnt_ff;
    logic div_ff;
    logic [3:0] half;

    // =========================================================
    // delay line
    // =========================================================
    // shift register gives 1 to 4 cycle delay
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dly_ff <= 4'h0;
        end else begin
            dly_ff <= {dly_ff[2:0], aux_in};
        end
    end

    always_comb begin
        dly_tap = dly_ff[dly_mode];
    end

    // =========================================================
    // even divider
    // =========================================================
    // div_sel 0 bypasses, k gives ratio 2k: toggle every k rising edges of tap
    always_comb begin
        half = {1'b0, div_sel};
    end

    logic tap_q_ff;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tap_q_ff <= 1'b0;
            cnt_ff <= 4'h0;
            div_ff <= 1'b0;
        end else begin
            tap_q_ff <= dly_tap;
            if (dly_tap && !tap_q_ff) begin
                if (cnt_ff + 4'h1 >= half) begin
                    cnt_ff <= 4'h0;
                    div_ff <= ~div_ff;
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end

    // output select, registered
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aux_out <= 1'b0;
        end else begin
            aux_out <= (div_sel == 3'h0) ? dly_tap : div_ff;
        end
    end

endmodule : pom_aux_clk

// file: core/pom_obs_mux.sv
`timescale 1ns/10ps
module pom_obs_mux (
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // internal observed signals, pin-side ones are asynchronous
    input wire logic xtal_in,
    input wire logic sine_ref_in,
    input wire logic ref_div_in,
    input wire logic prescaler_in,
    input wire logic lock_window_in,
    input wire logic pfd_up_raw,
    input wire logic pfd_dn_raw,
    input wire logic ref_faster_in,
    input wire logic vco_faster_in,
    input wire logic vco_locked_in,
    input wire logic ring_osc_in,
    input wire logic mod_clk_in,
    input wire logic aux_src_in,
    input wire logic [2:0] accum_msb_in,
    input wire logic [2:0] mod_out_in,
    // outputs
    output logic view_pin_1,
    output logic view_pin_2,
    output logic view_pin_3,
    output logic pump_up,
    output logic pump_dn,
    output logic pump_tristate,
    output logic frac_update,
    output logic [23:0] frac_value
);
    // =========================================================
    // three-stage synchroniser function
    // =========================================================
    // accept a change once stages two and three agree
    function automatic logic sync_pick(input logic [2:0] s, input logic held);
        sync_pick = (s[1] == s[2]) ? s[2] : held;
    endfunction : sync_pick

    localparam int NSYNC = 12;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    logic [NSYNC-1:0] clean_ff;

    // gather the pin-rate inputs into one vector for the synchroniser
    assign raw_in = {xtal_in, sine_ref_in, ref_div_in, prescaler_in, lock_window_in, pfd_up_raw,
                     pfd_dn_raw, ref_faster_in, vco_faster_in, vco_locked_in, ring_osc_in, mod_clk_in};

    // synchronise pin-rate inputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            clean_ff <= '0;
        end else begin
            s1_ff <= raw_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < NSYNC; i++) begin
                clean_ff[i] <= sync_pick({s3_ff[i], s2_ff[i], 1'b0}, clean_ff[i]);
            end
        end
    end

    logic c_xtal;
    logic c_sine;
    logic c_refdiv;
    logic c_presc;
    logic c_lockwin;
    logic c_up;
    logic c_dn;
    logic c_reffast;
    logic c_vcofast;
    logic c_locked;
    logic c_ring;
    logic c_modclk;
    // clean copies under their own names
    assign {c_xtal, c_sine, c_refdiv, c_presc, c_lockwin, c_up, c_dn,
            c_reffast, c_vcofast, c_locked, c_ring, c_modclk} = clean_ff;

    // =========================================================
    // configuration registers
    // =========================================================
    logic [3:0] sel_ff;
    logic [2:0] gpdata_ff;
    logic [2:0] pfd_ff;
    logic [6:0] aux_ff;
    logic [23:0] frac_ff;
    logic frac_wr;

    // strobe qualified by one register address
    function automatic logic addr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] reg_at);
        addr_hit = strobe && (addr == reg_at);
    endfunction : addr_hit

    // write to the fractional word starts a strobe request
    assign frac_wr = addr_hit(reg_wr, reg_addr, pom_pkg::ADDR_FRAC);

    // view select and general output data
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sel_ff <= pom_pkg::SEL_RST;
            gpdata_ff <= 3'h0;
        end else if (addr_hit(reg_wr, reg_addr, pom_pkg::ADDR_VIEW_CFG)) begin
            sel_ff <= reg_wdata[pom_pkg::SEL_LSB +: pom_pkg::SEL_W];
            gpdata_ff <= reg_wdata[pom_pkg::GPDATA_LSB +: pom_pkg::GPDATA_W];
        end
    end

    // detector polarity and pass bits
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pfd_ff <= pom_pkg::PFD_RST;
        end else if (addr_hit(reg_wr, reg_addr, pom_pkg::ADDR_PFD_CFG)) begin
            pfd_ff <= reg_wdata[2:0];
        end
    end

    // auxiliary clock configuration
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aux_ff <= pom_pkg::AUX_RST;
        end else if (addr_hit(reg_wr, reg_addr, pom_pkg::ADDR_AUX_CFG)) begin
            aux_ff <= reg_wdata[6:0];
        end
    end

    // fractional frequency word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            frac_ff <= '0;
        end else if (frac_wr) begin
            frac_ff <= reg_wdata[pom_pkg::FRAC_W-1:0];
        end
    end

    // =========================================================
    // fractional update strobe
    // =========================================================
    // write is held until the next rising edge of the reference divider
    pom_pkg::pom_fs_state_t fs_ff;
    logic refdiv_q_ff;
    logic ref_rise;
    logic fs_fire;
    logic again_ff;
    assign ref_rise = c_refdiv && !refdiv_q_ff;
    // strobe fires on the first reference rise while a write waits
    assign fs_fire = (fs_ff == pom_pkg::POM_FS_SYNC) && ref_rise;

    // previous level of the reference divider for edge detection
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            refdiv_q_ff <= 1'b0;
        end else begin
            refdiv_q_ff <= c_refdiv;
        end
    end

    // a write on the strobe edge latched too late, so it still owes a strobe
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            again_ff <= 1'b0;
        end else begin
            again_ff <= fs_fire && frac_wr;
        end
    end

    // strobe sequencer: wait for reference rise, then pulse
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fs_ff <= pom_pkg::POM_FS_IDLE;
        end else begin
            case (fs_ff)
                pom_pkg::POM_FS_IDLE: begin
                    if (frac_wr) begin
                        fs_ff <= pom_pkg::POM_FS_SYNC;
                    end
                end
                pom_pkg::POM_FS_SYNC: begin
                    if (ref_rise) begin
                        fs_ff <= pom_pkg::POM_FS_PULSE;
                    end
                end
                pom_pkg::POM_FS_PULSE: begin
                    fs_ff <= (frac_wr || again_ff) ? pom_pkg::POM_FS_SYNC : pom_pkg::POM_FS_IDLE;
                end
                default: begin
                    fs_ff <= pom_pkg::POM_FS_IDLE;
                end
            endcase
        end
    end

    // update strobe and latched word to the modulator
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            frac_update <= 1'b0;
            frac_value <= '0;
        end else begin
            frac_update <= fs_fire;
            if (fs_fire) begin
                frac_value <= frac_ff;
            end
        end
    end

    logic fs_pulse;
    // one-cycle copy of the strobe for the observation pin
    assign fs_pulse = (fs_ff == pom_pkg::POM_FS_PULSE);

    // =========================================================
    // detector polarity and masking
    // =========================================================
    logic up_pol;
    logic dn_pol;
    logic up_m;
    logic dn_m;
    // swap sense first, then apply the pass masks
    always_comb begin
        up_pol = pfd_ff[pom_pkg::POL_BIT] ? c_dn : c_up;
        dn_pol = pfd_ff[pom_pkg::POL_BIT] ? c_up : c_dn;
        up_m = up_pol && pfd_ff[pom_pkg::UP_PASS_BIT];
        dn_m = dn_pol && pfd_ff[pom_pkg::DN_PASS_BIT];
    end

    // charge pump drive
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pump_up <= 1'b0;
            pump_dn <= 1'b0;
            pump_tristate <= 1'b0;
        end else begin
            pump_up <= up_m;
            pump_dn <= dn_m;
            pump_tristate <= !pfd_ff[pom_pkg::UP_PASS_BIT] && !pfd_ff[pom_pkg::DN_PASS_BIT];
        end
    end

    // =========================================================
    // slip guard observation
    // =========================================================
    // max-gain hold stays up from first slip until lock
    logic slip_guard_hold_ff;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            slip_guard_hold_ff <= 1'b0;
        end else if (c_reffast || c_vcofast) begin
            slip_guard_hold_ff <= 1'b1;
        end else if (c_locked) begin
            slip_guard_hold_ff <= 1'b0;
        end
    end

    // =========================================================
    // auxiliary clock
    // =========================================================
    logic aux_clk;
    pom_aux_clk u_aux (
        .clock(clock),
        .reset_n(reset_n),
        .aux_in(aux_src_in),
        .dly_mode(aux_ff[pom_pkg::AUX_DLY_LSB +: pom_pkg::AUX_DLY_W]),
        .div_sel(aux_ff[pom_pkg::AUX_DIV_LSB +: pom_pkg::AUX_DIV_W]),
        .aux_out(aux_clk)
    );

    // =========================================================
    // view pin multiplexer
    // =========================================================
    logic [2:0] nxt_view; // {pin3, pin2, pin1}
    // pick the signal group for the current view select
    always_comb begin
        case (sel_ff)
            pom_pkg::SEL_GPDATA: nxt_view = gpdata_ff;
            pom_pkg::SEL_REFPATH: nxt_view = {c_xtal, c_refdiv, c_presc};
            pom_pkg::SEL_LOCKWIN: nxt_view = {up_m, dn_m, c_lockwin};
            pom_pkg::SEL_SLIP: nxt_view = {c_reffast, c_vcofast, slip_guard_hold_ff};
            pom_pkg::SEL_FRACSTB: nxt_view = {c_sine, c_refdiv, fs_pulse};
            pom_pkg::SEL_ACCUM: nxt_view = accum_msb_in;
            pom_pkg::SEL_AUXOSC: nxt_view = {aux_clk, c_ring, c_modclk};
            pom_pkg::SEL_MODOUT: nxt_view = mod_out_in;
            default: nxt_view = 3'h0;
        endcase
    end

    // register the pins so they leave straight from flip-flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            view_pin_1 <= 1'b0;
            view_pin_2 <= 1'b0;
            view_pin_3 <= 1'b0;
        end else begin
            view_pin_1 <= nxt_view[0];
            view_pin_2 <= nxt_view[1];
            view_pin_3 <= nxt_view[2];
        end
    end

    // =========================================================
    // register read
    // =========================================================
    // read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                pom_pkg::ADDR_VIEW_CFG: reg_rdata <= {25'h0, gpdata_ff, sel_ff};
                pom_pkg::ADDR_PFD_CFG: reg_rdata <= {29'h0, pfd_ff};
                pom_pkg::ADDR_AUX_CFG: reg_rdata <= {25'h0, aux_ff};
                pom_pkg::ADDR_FRAC: reg_rdata <= {8'h0, frac_ff};
                pom_pkg::ADDR_STATUS: reg_rdata <= {28'h0, slip_guard_hold_ff, fs_ff, pump_tristate};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule : pom_obs_mux

// file: tb/pom_obs_mux_properties.sv
`timescale 1ns/10ps
// ==========================================
// port checker for the observation mux
module pom_obs_mux_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [2:0] accum_msb_in,
    input wire logic [2:0] mod_out_in,
    input wire logic view_pin_1,
    input wire logic view_pin_2,
    input wire logic view_pin_3,
    input wire logic pump_up,
    input wire logic pump_tristate,
    input wire logic frac_update,
    input wire logic [23:0] frac_value
);
    logic [6:0] view_ff;
    logic [2:0] pfd_ff;
    logic [1:0] vage_ff, page_ff;
    logic pend_ff, fwr_ff;
    logic [23:0] word_ff;
    logic [2:0] pins;
    logic vwr, pwr, undoc;
    // pin bus with pin 3 on top, and the write decodes
    assign pins = {view_pin_3, view_pin_2, view_pin_1};
    assign vwr = reg_wr && reg_addr == pom_pkg::ADDR_VIEW_CFG;
    assign pwr = reg_wr && reg_addr == pom_pkg::ADDR_PFD_CFG;
    assign undoc = !(view_ff[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'ha});
    // shadow settings; the age saturates once pins have settled
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            view_ff <= 7'h00;
            pfd_ff <= pom_pkg::PFD_RST;
            vage_ff <= 2'h3;
            page_ff <= 2'h3;
        end else begin
            vage_ff <= vwr ? 2'h0 : vage_ff + {1'b0, vage_ff != 2'h3};
            page_ff <= pwr ? 2'h0 : page_ff + {1'b0, page_ff != 2'h3};
            view_ff <= vwr ? reg_wdata[6:0] : view_ff;
            pfd_ff <= pwr ? reg_wdata[2:0] : pfd_ff;
        end
    end
    // last frac word written and whether its strobe is still owed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pend_ff <= 1'b0;
            word_ff <= 24'h000000;
        end else if (reg_wr && reg_addr == pom_pkg::ADDR_FRAC) begin
            pend_ff <= 1'b1;
            word_ff <= reg_wdata[23:0];
        end else if (frac_update && !fwr_ff) begin
            pend_ff <= 1'b0;
        end
    end
    // a write one cycle back landed with the strobe, so one more strobe is owed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fwr_ff <= 1'b0;
        end else begin
            fwr_ff <= reg_wr && reg_addr == pom_pkg::ADDR_FRAC;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    gpdata_view_a: assert property (vage_ff == 2'h3 && view_ff[3:0] == 4'h0 |-> pins == view_ff[6:4])
        else $error("general data not on pins");
    unused_sel_a: assert property (vage_ff == 2'h3 && undoc |-> pins == 3'h0)
        else $error("unused select not low");
    accum_view_a: assert property ((vage_ff == 2'h3 && view_ff[3:0] == 4'h6 && $stable(accum_msb_in)) [*3]
        |-> pins == accum_msb_in) else $error("accumulator bits wrong");
    modout_view_a: assert property ((vage_ff == 2'h3 && view_ff[3:0] == 4'ha && $stable(mod_out_in)) [*3]
        |-> pins == mod_out_in) else $error("modulator bits wrong");
    tristate_level_a: assert property (page_ff == 2'h3 |-> pump_tristate == ~|pfd_ff[2:1])
        else $error("tristate level wrong");
    up_mask_a: assert property (page_ff == 2'h3 && !pfd_ff[1] |-> !pump_up)
        else $error("masked up pulse seen");
    strobe_pulse_a: assert property (frac_update |=> !frac_update)
        else $error("strobe longer than one cycle");
    strobe_cause_a: assert property (frac_update |-> pend_ff && frac_value == $past(word_ff))
        else $error("strobe without write or wrong word");
    strobe_pin_a: assert property (frac_update && vage_ff == 2'h3 && view_ff[3:0] == 4'h4
        |=> view_pin_1 ##1 !view_pin_1) else $error("strobe not shown on pin 1");
    cover property (frac_update);
    cover property (pump_tristate);
    cover property (vage_ff == 2'h3 && view_ff[3:0] == 4'h7 && $rose(view_pin_3));
endmodule : pom_obs_mux_chk

bind pom_obs_mux pom_obs_mux_chk u_chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .accum_msb_in(accum_msb_in), .mod_out_in(mod_out_in),
    .view_pin_1(view_pin_1), .view_pin_2(view_pin_2), .view_pin_3(view_pin_3), .pump_up(pump_up),
    .pump_tristate(pump_tristate), .frac_update(frac_update), .frac_value(frac_value));

// file: tb/pom_pin_watch.sv
`timescale 1ns/10ps
// ==========================================
// instrument on the view pins: trigger counter and period meter
module pom_pin_watch (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic view_pin_1,
    input wire logic view_pin_3,
    output logic [7:0] trig_cnt,
    output logic [7:0] aux_period
);
    logic pin1_ff, pin3_ff;
    logic [7:0] trig_ff, gap_ff, per_ff;
    assign trig_cnt = trig_ff;
    assign aux_period = per_ff;
    // count rises on pin 1, time pin 3 from rise to rise
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pin1_ff <= 1'b0;
            pin3_ff <= 1'b0;
            trig_ff <= 8'h00;
            gap_ff <= 8'h00;
            per_ff <= 8'h00;
        end else begin
            pin1_ff <= view_pin_1;
            pin3_ff <= view_pin_3;
            trig_ff <= trig_ff + {7'h00, view_pin_1 && !pin1_ff};
            gap_ff <= (view_pin_3 && !pin3_ff) ? 8'h00 : gap_ff + 8'h01;
            per_ff <= (view_pin_3 && !pin3_ff) ? gap_ff + 8'h01 : per_ff;
        end
    end
endmodule : pom_pin_watch

// file: tb/tb_pll_observation_output_mux.sv
`timescale 1ns/10ps
// ==========================================
// bench for the observation mux
module tb_pll_observation_output_mux;
    logic clock, reset_n, reg_wr, reg_rd, aux_run, phase0;
    logic [7:0] reg_addr, trig_cnt, aux_period, t;
    logic [31:0] reg_wdata, reg_rdata;
    logic xtal_in, sine_ref_in, ref_div_in, prescaler_in, lock_window_in, pfd_up_raw, pfd_dn_raw;
    logic ref_faster_in, vco_faster_in, vco_locked_in, ring_osc_in, mod_clk_in, aux_src_in;
    logic [2:0] accum_msb_in, mod_out_in;
    logic view_pin_1, view_pin_2, view_pin_3, pump_up, pump_dn, pump_tristate, frac_update;
    logic [23:0] frac_value;
    logic [3:0] undoc [7] = '{4'h5, 4'h8, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic [6:0] aux_cfg [4] = '{7'h00, 7'h10, 7'h2c, 7'h70};
    logic [7:0] aux_per [4] = '{8'h02, 8'h04, 8'h08, 8'h1c};
    int fail_count, compares, n;
    // design and pin instrument
    pom_obs_mux dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xtal_in(xtal_in), .sine_ref_in(sine_ref_in),
        .ref_div_in(ref_div_in), .prescaler_in(prescaler_in), .lock_window_in(lock_window_in),
        .pfd_up_raw(pfd_up_raw), .pfd_dn_raw(pfd_dn_raw), .ref_faster_in(ref_faster_in),
        .vco_faster_in(vco_faster_in), .vco_locked_in(vco_locked_in), .ring_osc_in(ring_osc_in),
        .mod_clk_in(mod_clk_in), .aux_src_in(aux_src_in), .accum_msb_in(accum_msb_in), .mod_out_in(mod_out_in),
        .view_pin_1(view_pin_1), .view_pin_2(view_pin_2), .view_pin_3(view_pin_3), .pump_up(pump_up),
        .pump_dn(pump_dn), .pump_tristate(pump_tristate), .frac_update(frac_update), .frac_value(frac_value));
    pom_pin_watch u_watch (.clock(clock), .reset_n(reset_n), .view_pin_1(view_pin_1),
        .view_pin_3(view_pin_3), .trig_cnt(trig_cnt), .aux_period(aux_period));
    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // aux source toggling every cycle while enabled
    always @(posedge clock) begin
        if (aux_run) begin
            aux_src_in <= ~aux_src_in;
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, exp);
        @(posedge clock);
    endtask : rd
    // exp holds tristate, up, down, then pins 3..1
    task automatic pins(input logic [5:0] exp);
        repeat (8) @(posedge clock);
        #1;
        chk("pins", {26'h0, pump_tristate, pump_up, pump_dn, view_pin_3, view_pin_2, view_pin_1}, {26'h0, exp});
        @(posedge clock);
    endtask : pins
    task automatic view(input logic [31:0] d, input logic [5:0] exp);
        wr(pom_pkg::ADDR_VIEW_CFG, d);
        pins(exp);
    endtask : view
    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        {reset_n, reg_wr, reg_rd, aux_run, aux_src_in, xtal_in, sine_ref_in, ref_div_in, prescaler_in} = '0;
        {lock_window_in, pfd_up_raw, pfd_dn_raw, ref_faster_in, vco_faster_in, vco_locked_in} = '0;
        {ring_osc_in, mod_clk_in, accum_msb_in, mod_out_in, reg_addr, reg_wdata} = '0;
        fail_count = 0;
        compares = 0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        rd(pom_pkg::ADDR_PFD_CFG, 32'h6);
        rd(8'h14, 32'h0);
        view(32'h50, 6'h05);
        $display("test general data done");
        xtal_in <= 1'b1;
        prescaler_in <= 1'b1;
        view(32'h1, 6'h05);
        ref_div_in <= 1'b1;
        view(32'h4, 6'h02);
        ref_div_in <= 1'b0;
        ref_faster_in <= 1'b1;
        view(32'h3, 6'h05);
        ref_faster_in <= 1'b0;
        vco_faster_in <= 1'b1;
        pins(6'h03);
        vco_faster_in <= 1'b0;
        vco_locked_in <= 1'b1;
        pins(6'h00);
        $display("test reference and slip views done");
        lock_window_in <= 1'b1;
        pfd_up_raw <= 1'b1;
        view(32'h2, 6'h15);
        wr(pom_pkg::ADDR_PFD_CFG, 32'h7);
        pins(6'h0b);
        wr(pom_pkg::ADDR_PFD_CFG, 32'h4);
        pins(6'h01);
        pfd_dn_raw <= 1'b1;
        wr(pom_pkg::ADDR_PFD_CFG, 32'h2);
        pins(6'h15);
        wr(pom_pkg::ADDR_PFD_CFG, 32'h0);
        pins(6'h21);
        rd(pom_pkg::ADDR_STATUS, 32'h1);
        pfd_up_raw <= 1'b0;
        pfd_dn_raw <= 1'b0;
        wr(pom_pkg::ADDR_PFD_CFG, 32'h6);
        $display("test detector views done");
        accum_msb_in <= 3'h6;
        view(32'h6, 6'h06);
        mod_out_in <= 3'h3;
        view(32'ha, 6'h03);
        for (int i = 0; i < 7; i++) begin
            view({25'h0, 3'h7, undoc[i]}, 6'h00);
        end
        ring_osc_in <= 1'b1;
        view(32'h7, 6'h02);
        aux_run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(pom_pkg::ADDR_AUX_CFG, {25'h0, aux_cfg[i]});
            repeat (100) @(posedge clock);
            #1;
            chk("aux period", {24'h0, aux_period}, {24'h0, aux_per[i]});
        end
        wr(pom_pkg::ADDR_AUX_CFG, 32'h0);
        repeat (10) @(posedge clock);
        #1;
        phase0 = view_pin_3 ^ aux_src_in;
        wr(pom_pkg::ADDR_AUX_CFG, 32'h4);
        repeat (10) @(posedge clock);
        #1;
        chk("aux delay", {31'h0, view_pin_3 ^ aux_src_in}, {31'h0, ~phase0});
        aux_run <= 1'b0;
        $display("test data and clock views done");
        view(32'h4, 6'h00);
        t = trig_cnt;
        wr(pom_pkg::ADDR_FRAC, 32'h00abcdef);
        wr(pom_pkg::ADDR_FRAC, 32'h00123456);
        ref_div_in <= 1'b1;
        n = 0;
        while (frac_update !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 40) begin
            fail_count++;
            results();
        end
        chk("frac word", {8'h0, frac_value}, 32'h00123456);
        repeat (4) @(posedge clock);
        #1;
        chk("triggers", {24'h0, trig_cnt}, {24'h0, t + 8'h01});
        $display("test frac strobe done");
        results();
    end
endmodule : tb_pll_observation_output_mux
